// ===== dsa_far_mem.sv
// far side model: special register bank and paged extended memory
`timescale 1ns/100ps
module dsa_far_mem
  import dsa_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        sfr_rd_i,
  input  wire logic        sfr_wr_i,
  input  wire logic [15:0] sfr_addr_i,
  input  wire logic        ext_rd_i,
  input  wire logic        ext_wr_i,
  input  wire logic [23:0] ext_addr_i,
  input  wire logic [1:0]  lane_we_i,
  input  wire logic [15:0] lane_wdata_i,
  output logic             sfr_impl_o,
  output logic [15:0]      sfr_rdata_o,
  output logic [15:0]      ext_rdata_o
);
  logic [15:0] sfr_mem [64];
  logic [15:0] ext_mem [64];
  logic [15:0] sfr_last_q;
  logic [15:0] ext_last_q;
  logic [5:0]  ext_idx;
  //////////////////////////////////////////////////////////////////////
  // only 0x0800..0x087F answers; the rest of the area is left unimplemented
  assign sfr_impl_o = (sfr_addr_i[15:7] == 9'h010);
  // small window: low three page bits and low word bits only, pages used apart by those
  assign ext_idx = {ext_addr_i[17:15], ext_addr_i[3:1]};
  initial
  begin
    foreach (ext_mem[i]) ext_mem[i] = 16'h0000;
  end
  // released data lines show the inverse of what they held the cycle before, so they toggle while idle
  always_comb
  begin
    sfr_rdata_o = sfr_rd_i ? sfr_mem[sfr_addr_i[6:1]] : ~sfr_last_q;
    ext_rdata_o = ext_rd_i ? ext_mem[ext_idx] : ~ext_last_q;
  end
  //////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i)
  begin
    sfr_last_q <= sfr_rdata_o;
    ext_last_q <= ext_rdata_o;
    if (sfr_wr_i && sfr_impl_o)
    begin
      if (lane_we_i[0]) sfr_mem[sfr_addr_i[6:1]][7:0] <= lane_wdata_i[7:0];
      if (lane_we_i[1]) sfr_mem[sfr_addr_i[6:1]][15:8] <= lane_wdata_i[15:8];
    end
    if (ext_wr_i)
    begin
      if (lane_we_i[0]) ext_mem[ext_idx][7:0] <= lane_wdata_i[7:0];
      if (lane_we_i[1]) ext_mem[ext_idx][15:8] <= lane_wdata_i[15:8];
    end
  end
endmodule

// ===== dsa_pkg.sv
// constants and types shared by the data space access unit
package dsa_pkg;

  // base space layout
  localparam logic [15:0] SFR_LAST_ADDR  = 16'h0FFF;
  localparam logic [15:0] RAM_FIRST_ADDR = 16'h1000;
  localparam int          RAM_BYTES_MAX  = 49152;
  localparam int          NEAR_FIELD_W   = 13;
  localparam int          EA_W           = 16;
  localparam int          PAGE_W         = 10;
  localparam int          EXT_ADDR_W     = 24;

  // page register values with special meaning
  localparam logic [9:0]  PG_ZERO        = 10'h000;
  localparam logic [9:0]  PG_BASE_HIGH   = 10'h001;
  localparam logic [9:0]  PG_EDS_LAST    = 10'h1FF;
  localparam logic [9:0]  PG_PSV_FIRST   = 10'h200;
  localparam logic [9:0]  PG_PSV_LSW_END = 10'h2FF;
  localparam logic [9:0]  PG_PSV_MSB_1ST = 10'h300;
  localparam logic [9:0]  PG_PSV_LAST    = 10'h3FF;
  localparam logic [9:0]  PG_ONE_STEP    = 10'h001;

  // reset values
  localparam logic [9:0]  READ_PAGE_RST  = 10'h001;
  localparam logic [9:0]  WRITE_PAGE_RST = 10'h001;
  localparam logic [15:0] WORD_RST       = 16'h0000;

  // pointer steps
  localparam logic [15:0] STEP_BYTE      = 16'h0001;
  localparam logic [15:0] STEP_WORD      = 16'h0002;

  // addressing mode of the current request
  typedef enum logic [3:0] {
    AM_NEAR,
    AM_DIRECT,
    AM_IND,
    AM_POSTINC,
    AM_POSTDEC,
    AM_PREINC,
    AM_PREDEC,
    AM_OFFSET,
    AM_MODULO,
    AM_BITREV
  } dsa_mode_t;

  // where a request lands
  typedef enum logic [1:0] {
    RG_NONE,
    RG_SFR,
    RG_RAM,
    RG_EXT
  } dsa_region_t;

endpackage

// ===== dsa_ram.sv
// byte-lane data memory with registered read data
`timescale 1ns/100ps
module dsa_ram
  import dsa_pkg::*;
#(
  parameter int DEPTH = 24576,
  parameter int AW    = 15
)
(
  input  wire logic          sys_clk_i,
  input  wire logic          reset_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [1:0]    we_i,
  input  wire logic [15:0]   wdata_i,
  output logic      [15:0]   rdata_o
);

  typedef struct packed {
    logic [15:0] rdata;
  } dsa_ram_state_t;

  logic [15:0]    mem [DEPTH];
  dsa_ram_state_t q;
  dsa_ram_state_t d;

  always_comb
  begin
    d       = q;
    d.rdata = mem[addr_i];
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      q.rdata <= WORD_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // the array itself has no reset; each lane has its own write line
  always_ff @(posedge sys_clk_i)
  begin
    if (we_i[0])
    begin
      mem[addr_i][7:0] <= wdata_i[7:0];
    end
    if (we_i[1])
    begin
      mem[addr_i][15:8] <= wdata_i[15:8];
    end
  end

  assign rdata_o = q.rdata;

endmodule

// ===== dsa_unit.sv
// data space access unit: address paging, byte lanes, alignment traps
`timescale 1ns/100ps
module dsa_unit
  import dsa_pkg::*;
#(
  parameter int RAM_BYTES = RAM_BYTES_MAX
)
(
  input  wire logic                  sys_clk_i,
  input  wire logic                  reset_i,
  input  wire logic                  req_i,
  input  wire logic                  write_i,
  input  wire logic                  byte_i,
  input  wire dsa_mode_t             mode_i,
  input  wire logic [EA_W-1:0]       ea_i,
  input  wire logic [EA_W-1:0]       ptr_i,
  input  wire logic [EA_W-1:0]       ofs_i,
  input  wire logic [15:0]           wdata_i,
  input  wire logic [15:0]           wreg_i,
  input  wire logic                  read_page_load_i,
  input  wire logic                  write_page_load_i,
  input  wire logic [PAGE_W-1:0]     page_wdata_i,
  input  wire logic                  sfr_impl_i,
  input  wire logic [15:0]           sfr_rdata_i,
  input  wire logic [15:0]           ext_rdata_i,
  output logic                       sfr_rd_o,
  output logic                       sfr_wr_o,
  output logic [EA_W-1:0]            sfr_addr_o,
  output logic                       ext_rd_o,
  output logic                       ext_wr_o,
  output logic                       ext_psv_o,
  output logic [EXT_ADDR_W-1:0]      ext_addr_o,
  output logic [1:0]                 lane_we_o,
  output logic [15:0]                lane_wdata_o,
  output logic [PAGE_W-1:0]          read_page_register_o,
  output logic [PAGE_W-1:0]          write_page_register_o,
  output logic                       rsp_valid_o,
  output logic [15:0]                rdata_o,
  output logic [15:0]                wreg_o,
  output logic                       ptr_we_o,
  output logic [EA_W-1:0]            ptr_o,
  output logic                       addr_error_o
);

  localparam int RAM_DEPTH = RAM_BYTES / 2;
  localparam int RAM_AW    = $clog2(RAM_DEPTH);
  localparam logic [16:0] RAM_END = 17'(RAM_FIRST_ADDR) + 17'(RAM_BYTES);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [PAGE_W-1:0] rpage;
    logic [PAGE_W-1:0] wpage;
    logic              s1_v;
    logic              s1_rd;
    logic              s1_byte;
    logic              s1_hi;
    logic              s1_err;
    dsa_region_t       s1_rg;
    logic [15:0]       s1_xdata;
    logic [15:0]       s1_wreg;
    logic              s1_pwe;
    logic [EA_W-1:0]   s1_ptr;
    logic              s2_v;
    logic [15:0]       s2_rdata;
    logic [15:0]       s2_wreg;
    logic              s2_pwe;
    logic [EA_W-1:0]   s2_ptr;
    logic              s2_err;
  } dsa_state_t;

  dsa_state_t q;
  dsa_state_t d;

  logic [EA_W-1:0]   addr;
  logic [EA_W-1:0]   nptr;
  logic [PAGE_W-1:0] page;
  logic [PAGE_W-1:0] apage;
  logic [PAGE_W-1:0] npage;
  logic [EA_W-1:0]   step;
  logic              win;
  logic              carry;
  logic              upward;
  logic              pre;
  logic              pmod;
  logic              mis;
  logic              pg_err;
  logic              err;
  logic              in_ram;
  dsa_region_t       rg;
  logic [1:0]        be;
  logic [15:0]       ram_rdata;
  logic [15:0]       word;
  logic [7:0]        sel_byte;
  logic [RAM_AW-1:0] ram_idx;
  logic [16:0]       ram_off;

  // returns {bit 15, page} after a page carry
  function automatic logic [PAGE_W:0] page_step(input logic up, input logic rd, input logic [PAGE_W-1:0] pg);
    logic [PAGE_W-1:0] inc;
    logic [PAGE_W-1:0] dec;
    inc = pg + PG_ONE_STEP;
    dec = pg - PG_ONE_STEP;
    page_step = up ? {1'b1, inc} : {1'b1, dec};
    if (up && (pg == PG_EDS_LAST || (rd && pg == PG_PSV_LAST)))
    begin
      page_step = {1'b0, pg};
    end
    if (!up && rd && (pg == PG_BASE_HIGH || pg == PG_PSV_FIRST))
    begin
      page_step = {1'b0, pg};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // address generation
  always_comb
  begin
    step   = byte_i ? STEP_BYTE : STEP_WORD;
    page   = write_i ? q.wpage : q.rpage;
    win    = ptr_i[15] && (page != PG_ZERO);
    addr   = ptr_i;
    nptr   = ptr_i;
    pre    = 1'b0;
    pmod   = 1'b0;
    upward = 1'b0;
    unique case (mode_i)
      AM_NEAR:
      begin
        addr = {3'h0, ea_i[NEAR_FIELD_W-1:0]};
      end
      AM_DIRECT:
      begin
        addr = ea_i;
      end
      AM_IND:
      begin
        addr = ptr_i;
      end
      AM_POSTINC, AM_PREINC:
      begin
        nptr   = ptr_i + step;
        pmod   = 1'b1;
        upward = 1'b1;
        pre    = (mode_i == AM_PREINC);
      end
      AM_POSTDEC, AM_PREDEC:
      begin
        nptr = ptr_i - step;
        pmod = 1'b1;
        pre  = (mode_i == AM_PREDEC);
      end
      AM_OFFSET:
      begin
        addr = ptr_i + ofs_i;
        if (win && !addr[15])
        begin
          addr[15] = 1'b1;
        end
      end
      AM_MODULO, AM_BITREV:
      begin
        nptr = ea_i;
        if (win && !nptr[15])
        begin
          nptr[15] = 1'b1;
        end
      end
      default:
      begin
        addr = ptr_i;
      end
    endcase
    // carry only from a paged window under pre/post modification
    carry = pmod && win && !nptr[15];
    npage = page;
    if (carry)
    begin
      {nptr[15], npage} = page_step(upward, !write_i, page);
    end
    if (pre)
    begin
      addr = nptr;
    end
    apage = pre ? npage : page;
  end

  ////////////////////////////////////////////////////////////////////////////
  // region decode and traps
  always_comb
  begin
    ram_off = 17'(addr) - 17'(RAM_FIRST_ADDR);
    in_ram  = (17'(addr) >= 17'(RAM_FIRST_ADDR)) && (17'(addr) < RAM_END);
    ram_idx = ram_off[RAM_AW:1];
    mis     = !byte_i && addr[0];
    pg_err  = 1'b0;
    rg      = RG_NONE;
    if (addr[15] && apage == PG_ZERO)
    begin
      pg_err = 1'b1;
    end
    else if (addr[15] && apage != PG_BASE_HIGH)
    begin
      pg_err = write_i && apage[PAGE_W-1];
      rg     = RG_EXT;
    end
    else if (addr <= SFR_LAST_ADDR)
    begin
      rg = sfr_impl_i ? RG_SFR : RG_NONE;
    end
    else if (in_ram)
    begin
      rg = RG_RAM;
    end
    err = req_i && (mis || pg_err);
    // lane strobes: even address is the low lane
    be  = byte_i ? (addr[0] ? 2'b10 : 2'b01) : 2'b11;
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory side strobes; a trapped write never reaches any target
  always_comb
  begin
    sfr_rd_o     = req_i && !write_i && rg == RG_SFR;
    sfr_wr_o     = req_i && write_i && !err && rg == RG_SFR;
    sfr_addr_o   = {addr[EA_W-1:1], 1'b0};
    ext_rd_o     = req_i && !write_i && !pg_err && rg == RG_EXT;
    ext_wr_o     = req_i && write_i && !err && rg == RG_EXT;
    ext_psv_o    = apage[PAGE_W-1];
    ext_addr_o   = {apage[PAGE_W-2:0], addr[14:1], 1'b0};
    lane_we_o    = (req_i && write_i && !err) ? be : 2'b00;
    lane_wdata_o = byte_i ? {wdata_i[7:0], wdata_i[7:0]} : wdata_i;
  end

  dsa_ram #(
    .DEPTH   (RAM_DEPTH),
    .AW      (RAM_AW)
  ) u_ram (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .addr_i    (ram_idx),
    .we_i      ((rg == RG_RAM) ? lane_we_o : 2'b00),
    .wdata_i   (lane_wdata_o),
    .rdata_o   (ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    d = q;
    // software load of a page register beats a carry in the same cycle
    if (req_i && carry && !write_i)
    begin
      d.rpage = npage;
    end
    if (req_i && carry && write_i)
    begin
      d.wpage = npage;
    end
    if (read_page_load_i)
    begin
      d.rpage = page_wdata_i;
    end
    if (write_page_load_i)
    begin
      d.wpage = page_wdata_i;
    end
    d.s1_v     = req_i;
    d.s1_rd    = !write_i;
    d.s1_byte  = byte_i;
    d.s1_hi    = addr[0];
    d.s1_err   = err;
    d.s1_rg    = pg_err ? RG_NONE : rg;
    d.s1_xdata = (rg == RG_SFR) ? sfr_rdata_i : ext_rdata_i;
    d.s1_wreg  = wreg_i;
    d.s1_pwe   = req_i && (pmod || mode_i == AM_MODULO || mode_i == AM_BITREV);
    d.s1_ptr   = nptr;
    // stage two: select word, then byte
    unique case (q.s1_rg)
      RG_RAM:  word = ram_rdata;
      RG_NONE: word = WORD_RST;
      default: word = q.s1_xdata;
    endcase
    sel_byte   = q.s1_hi ? word[15:8] : word[7:0];
    d.s2_v     = q.s1_v;
    d.s2_err   = q.s1_err;
    d.s2_pwe   = q.s1_pwe;
    d.s2_ptr   = q.s1_ptr;
    d.s2_rdata = q.s1_byte ? {8'h00, sel_byte} : word;
    d.s2_wreg  = q.s1_wreg;
    if (q.s1_v && q.s1_rd)
    begin
      d.s2_wreg = q.s1_byte ? {q.s1_wreg[15:8], sel_byte} : word;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      q       <= '0;
      q.rpage <= READ_PAGE_RST;
      q.wpage <= WRITE_PAGE_RST;
    end
    else
    begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // response, two edges after the request
  assign rsp_valid_o           = q.s2_v;
  assign rdata_o               = q.s2_rdata;
  assign wreg_o                = q.s2_wreg;
  assign ptr_we_o              = q.s2_pwe;
  assign ptr_o                 = q.s2_ptr;
  assign addr_error_o          = q.s2_err;
  assign read_page_register_o  = q.rpage;
  assign write_page_register_o = q.wpage;

  ////////////////////////////////////////////////////////////////////////////
  misaligned_trap_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (req_i && !byte_i && addr[0]) |-> ##2 (addr_error_o && rsp_valid_o))
    else $error("odd word access did not trap");

  write_suppress_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    err |-> (lane_we_o == 2'b00 && !sfr_wr_o && !ext_wr_o))
    else $error("trapped write reached memory");

  byte_lane_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (req_i && write_i && byte_i && !err) |-> (lane_we_o == (addr[0] ? 2'b10 : 2'b01)))
    else $error("byte write on wrong lane");

  step_size_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (req_i && mode_i == AM_POSTINC && !ptr_i[15]) |->
      ##2 (ptr_we_o && ptr_o == $past(ptr_i, 2) + ($past(byte_i, 2) ? STEP_BYTE : STEP_WORD)))
    else $error("post increment step wrong");

  zero_unmapped_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (req_i && !write_i && rg == RG_NONE && !err) |-> ##2 (rdata_o == WORD_RST))
    else $error("unmapped read not zero");

  byte_load_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (req_i && !write_i && byte_i) |-> ##2 (wreg_o[15:8] == $past(wreg_i[15:8], 2) && rdata_o[15:8] == 8'h00))
    else $error("byte load touched high byte");

  page_zero_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (req_i && addr[15] && apage == PG_ZERO) |-> ##2 addr_error_o)
    else $error("page zero window access not trapped");

  psv_write_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (req_i && write_i && addr[15] && q.wpage[PAGE_W-1]) |-> (!ext_wr_o ##2 addr_error_o))
    else $error("program space write not trapped");

  psv_cross_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (req_i && !write_i && carry && upward && q.rpage == PG_PSV_LSW_END && !read_page_load_i)
      |=> (read_page_register_o == PG_PSV_MSB_1ST))
    else $error("psv page did not advance to msb page");

  edge_page_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (req_i && !write_i && carry && upward && q.rpage == PG_EDS_LAST && !read_page_load_i)
      |=> (read_page_register_o == PG_EDS_LAST) ##1 (ptr_we_o && !ptr_o[15]))
    else $error("last eds page overflow not redirected to base");

  offset_wrap_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (req_i && mode_i == AM_OFFSET && win && !read_page_load_i && !write_page_load_i)
      |-> addr[15] ##1 ($stable(q.rpage) && $stable(q.wpage)))
    else $error("offset mode left the window");

endmodule

// ===== testbench.sv
// self-checking testbench for the data space access unit
`timescale 1ns/100ps
module testbench;
  import dsa_pkg::*;
  logic        sys_clk_i, reset_i, req_i, write_i, byte_i, read_page_load_i, write_page_load_i, sfr_impl_i;
  dsa_mode_t   mode_i;
  logic [15:0] ea_i, ptr_i, ofs_i, wdata_i, wreg_i, sfr_rdata_i, ext_rdata_i, sfr_addr_o, lane_wdata_o;
  logic [15:0] rdata_o, wreg_o, ptr_o, c_sa, c_wd;
  logic [9:0]  page_wdata_i, read_page_register_o, write_page_register_o;
  logic        sfr_rd_o, sfr_wr_o, ext_rd_o, ext_wr_o, ext_psv_o, rsp_valid_o, ptr_we_o, addr_error_o;
  logic        c_erd, c_ewr, c_psv, c_srd, c_swr;
  logic [23:0] ext_addr_o, c_ea;
  logic [1:0]  lane_we_o, c_we;
  int          fail_count, n_tests;
  //////////////////////////////////////////////////////////////////////
  dsa_unit #(.RAM_BYTES(256)) dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .req_i(req_i), .write_i(write_i),
    .byte_i(byte_i), .mode_i(mode_i), .ea_i(ea_i), .ptr_i(ptr_i), .ofs_i(ofs_i), .wdata_i(wdata_i),
    .wreg_i(wreg_i), .read_page_load_i(read_page_load_i), .write_page_load_i(write_page_load_i),
    .page_wdata_i(page_wdata_i), .sfr_impl_i(sfr_impl_i), .sfr_rdata_i(sfr_rdata_i),
    .ext_rdata_i(ext_rdata_i), .sfr_rd_o(sfr_rd_o), .sfr_wr_o(sfr_wr_o), .sfr_addr_o(sfr_addr_o),
    .ext_rd_o(ext_rd_o), .ext_wr_o(ext_wr_o), .ext_psv_o(ext_psv_o), .ext_addr_o(ext_addr_o),
    .lane_we_o(lane_we_o), .lane_wdata_o(lane_wdata_o), .read_page_register_o(read_page_register_o),
    .write_page_register_o(write_page_register_o), .rsp_valid_o(rsp_valid_o), .rdata_o(rdata_o),
    .wreg_o(wreg_o), .ptr_we_o(ptr_we_o), .ptr_o(ptr_o), .addr_error_o(addr_error_o));
  dsa_far_mem far_u (.sys_clk_i(sys_clk_i), .sfr_rd_i(sfr_rd_o), .sfr_wr_i(sfr_wr_o), .sfr_addr_i(sfr_addr_o),
    .ext_rd_i(ext_rd_o), .ext_wr_i(ext_wr_o), .ext_addr_i(ext_addr_o), .lane_we_i(lane_we_o),
    .lane_wdata_i(lane_wdata_o), .sfr_impl_o(sfr_impl_i), .sfr_rdata_o(sfr_rdata_i), .ext_rdata_o(ext_rdata_i));
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one request, strobes caught in the request cycle, answer judged two cycles on
  task automatic acc(input logic w, input logic b, input dsa_mode_t m, input logic [15:0] ea, input logic [15:0] p,
                     input logic [15:0] d);
    @(negedge sys_clk_i);
    req_i = 1'b1; write_i = w; byte_i = b; mode_i = m; ea_i = ea; ptr_i = p; wdata_i = d;
    #1;
    c_we = lane_we_o; c_erd = ext_rd_o; c_ewr = ext_wr_o; c_psv = ext_psv_o; c_srd = sfr_rd_o;
    c_ea = ext_addr_o; c_sa = sfr_addr_o; c_swr = sfr_wr_o; c_wd = lane_wdata_o;
    @(negedge sys_clk_i);
    req_i = 1'b0;
    chk(rsp_valid_o, 1'b0);
    @(negedge sys_clk_i);
    chk(rsp_valid_o, 1'b1);
  endtask
  task automatic pg(input logic rd, input logic [9:0] v);
    @(negedge sys_clk_i);
    read_page_load_i = rd; write_page_load_i = !rd; page_wdata_i = v;
    @(negedge sys_clk_i);
    read_page_load_i = 1'b0; write_page_load_i = 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    reset_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk(read_page_register_o, 10'h001);
    chk(write_page_register_o, 10'h001);
    chk(rsp_valid_o, 1'b0);
    reset_i = 1'b0;
    @(negedge sys_clk_i);
    chk(rsp_valid_o, 1'b0);
    chk(addr_error_o, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_lanes();
    acc(1, 0, AM_DIRECT, 16'h1010, 0, 16'h1234);
    chk(c_we, 2'h3);
    acc(0, 1, AM_DIRECT, 16'h1010, 0, 0);  chk(rdata_o, 16'h0034);
    acc(0, 1, AM_DIRECT, 16'h1011, 0, 0);  chk(rdata_o, 16'h0012);
    acc(1, 1, AM_DIRECT, 16'h1011, 0, 16'h00AB);
    chk(c_we, 2'h2);
    chk(c_wd, 16'hABAB);
    acc(0, 0, AM_DIRECT, 16'h1010, 0, 0);  chk(rdata_o, 16'hAB34);
    wreg_i = 16'hCC55;
    acc(0, 1, AM_DIRECT, 16'h1010, 0, 0);  chk(wreg_o, 16'hCC34);
    acc(0, 1, AM_POSTINC, 0, 16'h1010, 0); chk(ptr_o, 16'h1011);
    chk(ptr_we_o, 1'b1);
    acc(0, 0, AM_POSTINC, 0, 16'h1010, 0); chk(ptr_o, 16'h1012);
    $display("test lanes done");
  endtask
  task automatic t_align();
    acc(1, 0, AM_DIRECT, 16'h1012, 0, 16'h5A5A); chk(addr_error_o, 1'b0);
    acc(0, 0, AM_DIRECT, 16'h1011, 0, 0);        chk(addr_error_o, 1'b1);
    acc(1, 0, AM_DIRECT, 16'h1013, 0, 16'hFFFF); chk(addr_error_o, 1'b1);
    chk(c_we, 2'h0);
    acc(0, 0, AM_DIRECT, 16'h1012, 0, 0);        chk(rdata_o, 16'h5A5A);
    $display("test align done");
  endtask
  task automatic t_space();
    acc(0, 0, AM_DIRECT, 16'h2000, 0, 0); chk(rdata_o, 16'h0000);
    acc(0, 0, AM_DIRECT, 16'h9000, 0, 0); chk(rdata_o, 16'h0000);
    acc(1, 0, AM_DIRECT, 16'h0802, 0, 16'hBEEF);
    chk(c_swr, 1'b1);
    acc(0, 0, AM_DIRECT, 16'h0F00, 0, 0); chk(rdata_o, 16'h0000);
    chk(c_srd, 1'b0);
    acc(0, 0, AM_NEAR, 16'hE802, 0, 0);   chk(rdata_o, 16'hBEEF);
    chk(c_sa, 16'h0802);
    acc(0, 0, AM_IND, 0, 16'h0802, 0);    chk(rdata_o, 16'hBEEF);
    $display("test space done");
  endtask
  task automatic t_pages();
    pg(1, 10'h005);
    pg(0, 10'h00A);
    chk(read_page_register_o, 10'h005);
    acc(1, 0, AM_DIRECT, 16'h8010, 0, 16'h7777);
    chk(c_ewr, 1'b1);
    chk(c_ea, {9'h00A, 14'h0008, 1'b0});
    acc(0, 0, AM_DIRECT, 16'h8010, 0, 0); chk(c_ea, {9'h005, 14'h0008, 1'b0});
    chk(rdata_o, 16'h0000);
    chk(c_erd, 1'b1);
    pg(1, 10'h00A);
    acc(0, 0, AM_DIRECT, 16'h8010, 0, 0); chk(rdata_o, 16'h7777);
    pg(1, 10'h005);
    ofs_i = 16'h0004;
    acc(0, 0, AM_OFFSET, 0, 16'hFFFE, 0); chk(c_ea, {9'h005, 14'h0001, 1'b0});
    chk(read_page_register_o, 10'h005);
    chk(ptr_we_o, 1'b0);
    $display("test pages done");
  endtask
  task automatic carry(input logic [9:0] p, input dsa_mode_t m, input logic [15:0] q, input logic [9:0] ep,
                       input logic [15:0] eq);
    pg(1, p);
    acc(0, 0, m, 16'h0000, q, 0);
    chk(read_page_register_o, ep);
    chk(ptr_o, eq);
    chk(ptr_we_o, 1'b1);
  endtask
  task automatic t_carry();
    carry(10'h005, AM_POSTINC, 16'hFFFE, 10'h006, 16'h8000);
    carry(10'h005, AM_POSTDEC, 16'h8000, 10'h004, 16'hFFFE);
    carry(10'h005, AM_POSTINC, 16'h7FFE, 10'h005, 16'h8000);
    carry(10'h005, AM_MODULO, 16'hFFFE, 10'h005, 16'h8000);
    carry(10'h005, AM_BITREV, 16'hFFFE, 10'h005, 16'h8000);
    carry(10'h1FF, AM_POSTINC, 16'hFFFE, 10'h1FF, 16'h0000);
    carry(10'h3FF, AM_PREINC, 16'hFFFE, 10'h3FF, 16'h0000);
    carry(10'h001, AM_POSTDEC, 16'h8000, 10'h001, 16'h7FFE);
    carry(10'h200, AM_PREDEC, 16'h8000, 10'h200, 16'h7FFE);
    carry(10'h2FF, AM_POSTINC, 16'hFFFE, 10'h300, 16'h8000);
    carry(10'h300, AM_PREDEC, 16'h8000, 10'h2FF, 16'hFFFE);
    pg(0, 10'h1FF);
    acc(1, 0, AM_POSTINC, 0, 16'hFFFE, 16'h0001); chk(write_page_register_o, 10'h1FF);
    chk(ptr_o, 16'h0000);
    $display("test carry done");
  endtask
  task automatic t_traps();
    pg(1, 10'h000);
    acc(0, 0, AM_DIRECT, 16'h8010, 0, 0); chk(addr_error_o, 1'b1);
    chk(c_erd, 1'b0);
    pg(1, 10'h200);
    acc(0, 0, AM_DIRECT, 16'h8010, 0, 0); chk(addr_error_o, 1'b0);
    chk(c_psv, 1'b1);
    pg(0, 10'h200);
    acc(1, 0, AM_DIRECT, 16'h8010, 0, 16'h1111); chk(addr_error_o, 1'b1);
    chk(c_ewr, 1'b0);
    chk(c_we, 2'h0);
    $display("test traps done");
  endtask
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    fail_count = 0; n_tests = 0;
    reset_i = 1'b1; req_i = 1'b0; write_i = 1'b0; byte_i = 1'b0; mode_i = AM_DIRECT;
    ea_i = 16'h0000; ptr_i = 16'h0000; ofs_i = 16'h0000; wdata_i = 16'h0000; wreg_i = 16'h0000;
    read_page_load_i = 1'b0; write_page_load_i = 1'b0; page_wdata_i = 10'h000;
    t_reset();
    t_lanes();
    t_align();
    t_space();
    t_pages();
    t_reset();
    t_carry();
    t_traps();
    close_out();
  end
  // whole run is under two hundred cycles; this limit only trips on a hang
  initial
  begin
    #50000;
    fail_count++;
    close_out();
  end
endmodule
